// *** rtl/nirq_core.sv ***
// Purpose: interrupt request / enable registers and interrupt pin driver
// Assumes: event inputs are one-cycle pulses on core_clk; live levels are synchronous
// Notes: secure_link_input is a pin and is synchronised here
//   register reads are combinational on the addressed index
//   a hardware event in the cycle of a host clear leaves the flag set
//   open-drain mode never drives the pin high; the line needs a pull-up
`timescale 1ns/10ps
`include "nirq_consts.svh"
module nirq_core (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [5:0] reg_addr,
  input wire logic reg_wr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic tx_last_bit_sent,
  input wire logic rx_stream_end,
  input wire logic rx_no_fault_option,
  input wire logic fifo_not_empty,
  input wire logic cmd_self_end,
  input wire logic cmd_unknown_start,
  input wire logic fifo_high_live,
  input wire logic fifo_low_live,
  input wire logic [7:0] error_bits,
  input wire logic countdown_zero,
  input wire logic secure_link_input,
  input wire logic mode_detected,
  input wire logic checksum_active,
  input wire logic checksum_all_done,
  input wire logic field_present,
  output logic cmd_force_idle,
  output logic irq_status,
  output logic irq_pin_out,
  output logic irq_pin_oe
);
  import nirq_pkg::*;

  // ****************************************
  // registers
  // ****************************************
  nirq_pkg::nirq_comm_t comm_irq_request, next_comm_irq_request;
  nirq_pkg::nirq_misc_t misc_irq_request, next_misc_irq_request;
  logic [7:0] comm_irq_enable, next_comm_irq_enable;
  logic [7:0] misc_irq_enable, next_misc_irq_enable;
  logic [2:0] sig_sync, next_sig_sync;
  logic sig_stable, next_sig_stable;
  logic field_prev, next_field_prev;
  logic high_prev, next_high_prev;
  logic low_prev, next_low_prev;
  logic [1:0] sig_fill, next_sig_fill;
  logic field_started, next_field_started;

  logic pin_polarity_invert;
  logic pin_drive_select;
  logic comm_set_clear_select;
  logic misc_set_clear_select;
  nirq_pkg::nirq_comm_t comm_events;
  nirq_pkg::nirq_misc_t misc_events;
  logic sig_edge;
  logic wr_comm_req;
  logic wr_misc_req;
  logic wr_comm_en;
  logic wr_misc_en;
  logic sig_armed;

  assign pin_polarity_invert = comm_irq_enable[`NIRQ_BIT_INVERT];
  assign pin_drive_select = misc_irq_enable[`NIRQ_BIT_DRIVE];
  assign comm_set_clear_select = reg_wdata[`NIRQ_BIT_SET_CLEAR];
  assign misc_set_clear_select = reg_wdata[`NIRQ_BIT_SET_CLEAR];
  assign wr_comm_req = reg_wr && (reg_addr == `NIRQ_ADDR_COMM_REQUEST);
  assign wr_misc_req = reg_wr && (reg_addr == `NIRQ_ADDR_MISC_REQUEST);
  assign wr_comm_en = reg_wr && (reg_addr == `NIRQ_ADDR_COMM_ENABLE);
  assign wr_misc_en = reg_wr && (reg_addr == `NIRQ_ADDR_MISC_ENABLE);
  assign sig_armed = (sig_fill == 2'h3);
  assign cmd_force_idle = cmd_unknown_start;

  // ****************************************
  // named fields of the registers
  // ****************************************
  // aliases keep the gating terms readable against the bit map
  logic tx_done_enable;
  logic rx_done_enable;
  logic cmd_end_enable;
  logic fifo_high_enable;
  logic fifo_low_enable;
  logic fault_enable;
  logic countdown_enable;
  logic sig_input_enable;
  logic mode_detect_enable;
  logic checksum_done_enable;
  logic field_on_enable;
  logic field_off_enable;

  logic tx_done_flag;
  logic rx_done_flag;
  logic cmd_end_flag;
  logic fifo_high_flag;
  logic fifo_low_flag;
  logic fault_flag;
  logic countdown_flag;
  logic sig_input_flag;
  logic mode_detect_flag;
  logic checksum_done_flag;
  logic field_on_flag;
  logic field_off_flag;

  logic [11:0] gated_requests;

  // comm enable fields
  assign tx_done_enable = comm_irq_enable[6];
  assign rx_done_enable = comm_irq_enable[5];
  assign cmd_end_enable = comm_irq_enable[4];
  assign fifo_high_enable = comm_irq_enable[3];
  assign fifo_low_enable = comm_irq_enable[2];
  assign fault_enable = comm_irq_enable[1];
  assign countdown_enable = comm_irq_enable[0];

  // misc enable fields
  assign sig_input_enable = misc_irq_enable[4];
  assign mode_detect_enable = misc_irq_enable[3];
  assign checksum_done_enable = misc_irq_enable[2];
  assign field_on_enable = misc_irq_enable[1];
  assign field_off_enable = misc_irq_enable[0];

  // comm request flags
  assign tx_done_flag = comm_irq_request[6];
  assign rx_done_flag = comm_irq_request[5];
  assign cmd_end_flag = comm_irq_request[4];
  assign fifo_high_flag = comm_irq_request[3];
  assign fifo_low_flag = comm_irq_request[2];
  assign fault_flag = comm_irq_request[1];
  assign countdown_flag = comm_irq_request[0];

  // misc request flags
  assign sig_input_flag = misc_irq_request[4];
  assign mode_detect_flag = misc_irq_request[3];
  assign checksum_done_flag = misc_irq_request[2];
  assign field_on_flag = misc_irq_request[1];
  assign field_off_flag = misc_irq_request[0];

  // each request reaches the pin only through its own enable
  assign gated_requests[11] = tx_done_flag & tx_done_enable;
  assign gated_requests[10] = rx_done_flag & rx_done_enable;
  assign gated_requests[9] = cmd_end_flag & cmd_end_enable;
  assign gated_requests[8] = fifo_high_flag & fifo_high_enable;
  assign gated_requests[7] = fifo_low_flag & fifo_low_enable;
  assign gated_requests[6] = fault_flag & fault_enable;
  assign gated_requests[5] = countdown_flag & countdown_enable;
  assign gated_requests[4] = sig_input_flag & sig_input_enable;
  assign gated_requests[3] = mode_detect_flag & mode_detect_enable;
  assign gated_requests[2] = checksum_done_flag & checksum_done_enable;
  assign gated_requests[1] = field_on_flag & field_on_enable;
  assign gated_requests[0] = field_off_flag & field_off_enable;

  // ****************************************
  // event sources
  // ****************************************
  always_comb begin
    comm_events[6] = tx_last_bit_sent;
    comm_events[5] = rx_stream_end && (!rx_no_fault_option || fifo_not_empty);
    comm_events[4] = cmd_self_end || cmd_unknown_start;
    // alert flags latch on the rising edge of the live level
    comm_events[3] = fifo_high_live && !high_prev;
    comm_events[2] = fifo_low_live && !low_prev;
    comm_events[1] = |error_bits;
    comm_events[0] = countdown_zero;
    sig_edge = sig_armed && (sig_sync[2] == sig_sync[1]) && (sig_sync[1] != sig_stable);
    misc_events[4] = sig_edge;
    misc_events[3] = mode_detected;
    misc_events[2] = checksum_active && checksum_all_done;
    // field history is not valid in the first cycle after reset
    misc_events[1] = field_started && field_present && !field_prev;
    misc_events[0] = field_started && !field_present && field_prev;
  end

  // ****************************************
  // next state
  // ****************************************
  always_comb begin
    next_comm_irq_enable = comm_irq_enable;
    next_misc_irq_enable = misc_irq_enable;
    next_comm_irq_request = comm_irq_request;
    next_misc_irq_request = misc_irq_request;
    if (wr_comm_en) begin
      next_comm_irq_enable = reg_wdata;
    end
    if (wr_misc_en) begin
      next_misc_irq_enable = reg_wdata & {1'b1, 2'b00, `NIRQ_MISC_MASK};
    end
    if (wr_comm_req) begin
      if (comm_set_clear_select) begin
        next_comm_irq_request = comm_irq_request | reg_wdata[6:0];
      end else begin
        next_comm_irq_request = comm_irq_request & ~reg_wdata[6:0];
      end
    end
    if (wr_misc_req) begin
      if (misc_set_clear_select) begin
        next_misc_irq_request = misc_irq_request | reg_wdata[4:0];
      end else begin
        next_misc_irq_request = misc_irq_request & ~reg_wdata[4:0];
      end
    end
    // hardware set wins over a same-cycle clear
    next_comm_irq_request = next_comm_irq_request | comm_events;
    next_misc_irq_request = next_misc_irq_request | misc_events;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      comm_irq_enable <= `NIRQ_RST_COMM_ENABLE;
      misc_irq_enable <= `NIRQ_RST_MISC_ENABLE;
      comm_irq_request <= `NIRQ_RST_COMM_REQUEST;
      misc_irq_request <= 5'h0_0;
    end else begin
      comm_irq_enable <= next_comm_irq_enable;
      misc_irq_enable <= next_misc_irq_enable;
      comm_irq_request <= next_comm_irq_request;
      misc_irq_request <= next_misc_irq_request;
    end
  end

  // ****************************************
  // input history
  // ****************************************
  always_comb begin
    next_sig_sync = {sig_sync[1:0], secure_link_input};
    // until the pipe holds real pin samples the stable level tracks it, so reset makes no false edge
    next_sig_stable = (!sig_armed || (sig_sync[2] == sig_sync[1])) ? sig_sync[1] : sig_stable;
    next_sig_fill = sig_armed ? sig_fill : sig_fill + 2'h1;
    next_field_prev = field_present;
    next_field_started = 1'b1;
    next_high_prev = fifo_high_live;
    next_low_prev = fifo_low_live;
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      sig_sync <= 3'h0;
      sig_stable <= 1'b0;
      sig_fill <= 2'h0;
      field_prev <= 1'b0;
      field_started <= 1'b0;
      high_prev <= 1'b0;
      low_prev <= 1'b0;
    end else begin
      sig_sync <= next_sig_sync;
      sig_stable <= next_sig_stable;
      sig_fill <= next_sig_fill;
      field_prev <= next_field_prev;
      field_started <= next_field_started;
      high_prev <= next_high_prev;
      low_prev <= next_low_prev;
    end
  end

  // ****************************************
  // read back and pin
  // ****************************************
  always_comb begin
    unique case (reg_addr)
      `NIRQ_ADDR_COMM_ENABLE: reg_rdata = comm_irq_enable;
      `NIRQ_ADDR_MISC_ENABLE: reg_rdata = misc_irq_enable;
      `NIRQ_ADDR_COMM_REQUEST: reg_rdata = {1'b0, comm_irq_request};
      `NIRQ_ADDR_MISC_REQUEST: reg_rdata = {3'b000, misc_irq_request};
      // unmapped indices read zero
      default: reg_rdata = 8'h00;
    endcase
  end

  logic pin_level;
  always_comb begin
    irq_status = |gated_requests;
    pin_level = irq_status ^ pin_polarity_invert;
    irq_pin_out = pin_level;
    // open drain: only a low level is driven, a high level is left to the pull-up
    irq_pin_oe = pin_drive_select | !pin_level;
  end
endmodule : nirq_core

// *** rtl/nirq_consts.svh ***
// Purpose: offsets, field positions, reset values of the interrupt logic registers
// Assumes: 6-bit register index on the host register port
// Notes: included by the design file only
`ifndef NIRQ_CONSTS_SVH
`define NIRQ_CONSTS_SVH
`define NIRQ_ADDR_COMM_ENABLE 6'h02
`define NIRQ_ADDR_MISC_ENABLE 6'h03
`define NIRQ_ADDR_COMM_REQUEST 6'h04
`define NIRQ_ADDR_MISC_REQUEST 6'h05
`define NIRQ_RST_COMM_ENABLE 8'h80
`define NIRQ_RST_MISC_ENABLE 8'h00
`define NIRQ_RST_COMM_REQUEST 7'h14
`define NIRQ_BIT_SET_CLEAR 7
`define NIRQ_BIT_INVERT 7
`define NIRQ_BIT_DRIVE 7
`define NIRQ_MISC_MASK 5'h1f
`endif

// *** rtl/nirq_pkg.sv ***
// Purpose: types shared by the interrupt logic
// Assumes: nothing
// Notes: constants live in nirq_consts.svh
package nirq_pkg;
  typedef logic [6:0] nirq_comm_t;
  typedef logic [4:0] nirq_misc_t;
endpackage : nirq_pkg

// *** sim/nirq_chk.sv ***
// Purpose: checker on nirq_core ports
// Assumes: sync reset
// Notes: bound at foot
`timescale 1ns/10ps
module nirq_chk (
  input logic core_clk,
  input logic rst_n,
  input logic [5:0] reg_addr,
  input logic reg_wr,
  input logic [7:0] reg_wdata,
  input logic [7:0] reg_rdata,
  input logic tx_last_bit_sent,
  input logic cmd_unknown_start,
  input logic cmd_force_idle,
  input logic irq_status,
  input logic irq_pin_out,
  input logic irq_pin_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_inv_wr; reg_wr && reg_addr == 6'h02; endsequence
  sequence s_clr_tx; reg_wr && reg_addr == 6'h04 && reg_wdata[7:6] == 2'b01 && !tx_last_bit_sent
    ##1 reg_addr == 6'h04; endsequence
  a_pin_polarity: assert property (s_inv_wr |=> irq_pin_out == (irq_status ^ $past(reg_wdata[7])))
    else $error("pin polarity");
  a_reset_float: assert property ($rose(rst_n) |-> irq_pin_out && !irq_pin_oe) else $error("pin at reset");
  a_open_drain: assert property (!irq_pin_oe |-> irq_pin_out) else $error("released low");
  a_push_pull: assert property (reg_wr && reg_addr == 6'h03 && reg_wdata[7] |=> irq_pin_oe)
    else $error("push-pull released");
  a_drain_mode: assert property (reg_wr && reg_addr == 6'h03 && !reg_wdata[7] |=> irq_pin_oe == !irq_pin_out)
    else $error("open-drain drive");
  a_tx_flag: assert property (tx_last_bit_sent ##1 reg_addr == 6'h04 |-> reg_rdata[6]) else $error("tx flag");
  a_idle_unknown: assert property (cmd_unknown_start |-> cmd_force_idle ##1 (reg_addr != 6'h04 || reg_rdata[4]))
    else $error("unknown cmd");
  a_clear_tx: assert property (s_clr_tx |-> !reg_rdata[6]) else $error("clear");
  a_bit7_zero: assert property (reg_addr inside {6'h04, 6'h05} |-> !reg_rdata[7]) else $error("bit 7");
  a_rsvd_zero: assert property (reg_addr inside {6'h03, 6'h05} |-> reg_rdata[6:5] == 2'b00) else $error("rsvd");
endmodule : nirq_chk
bind nirq_core nirq_chk u_chk (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .tx_last_bit_sent,
  .cmd_unknown_start, .cmd_force_idle, .irq_status, .irq_pin_out, .irq_pin_oe);

// *** sim/nirq_host.sv ***
// Purpose: host view of the irq pin
// Assumes: pull-up on the line
// Notes: released pin reads high
`timescale 1ns/10ps
module nirq_host (
  input logic irq_pin_out,
  input logic irq_pin_oe,
  output logic irq_seen
);
  assign irq_seen = irq_pin_oe ? irq_pin_out : 1'b1;
endmodule : nirq_host

// *** sim/nirq_core_tb.sv ***
// Purpose: bench of nirq_core
// Assumes: 100 MHz clock
// Notes: ev bits drive event sources
`timescale 1ns/10ps
module nirq_core_tb;
  logic core_clk = 0, rst_n = 0, reg_wr = 0, opt = 0, fne = 0;
  logic cmd_force_idle, irq_status, irq_pin_out, irq_pin_oe, irq_seen;
  logic [5:0] reg_addr = 6'h00;
  logic [7:0] reg_wdata = 8'h00, reg_rdata;
  logic [11:0] ev = 12'h000;
  logic [7:0] ew [12] = '{8'h40, 8'h20, 8'h10, 8'h10, 8'h08, 8'h04, 8'h02, 8'h01, 8'h08, 8'h04, 8'h03, 8'h10};
  int fails = 0, n_compared = 0;
  always #5 core_clk = ~core_clk;
  nirq_core uut (.core_clk, .rst_n, .reg_addr, .reg_wr, .reg_wdata, .reg_rdata, .tx_last_bit_sent(ev[0]),
    .rx_stream_end(ev[1]), .rx_no_fault_option(opt), .fifo_not_empty(fne), .cmd_self_end(ev[2]),
    .cmd_unknown_start(ev[3]), .fifo_high_live(ev[4]), .fifo_low_live(ev[5]), .error_bits({ev[6], 7'h00}),
    .countdown_zero(ev[7]), .secure_link_input(ev[11]), .mode_detected(ev[8]), .checksum_active(ev[9]),
    .checksum_all_done(ev[9]), .field_present(ev[10]), .cmd_force_idle, .irq_status, .irq_pin_out, .irq_pin_oe);
  nirq_host u_host (.irq_pin_out, .irq_pin_oe, .irq_seen);
  task automatic chk(input logic [7:0] seen, input logic [7:0] want);
    n_compared++;
    if (seen !== want) begin
      fails++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, want);
    end
  endtask : chk
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge core_clk) #1 reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge core_clk) #1 reg_wr = 0;
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] want);
    @(posedge core_clk) #1 reg_addr = a;
    #1 chk(reg_rdata, want);
  endtask : rd
  task automatic pin(input logic [7:0] want);
    chk({4'h0, irq_status, irq_pin_out, irq_pin_oe, irq_seen}, want);
  endtask : pin
  task automatic fire(input int i, input logic [7:0] want);
    int k;
    @(posedge core_clk) #1 reg_addr = i < 8 ? 6'h04 : 6'h05;
    ev[i] = 1;
    #1 chk({7'h00, cmd_force_idle}, {7'h00, i == 3});
    repeat (3) @(posedge core_clk);
    #1 ev[i] = 0;
    for (k = 0; k < 20 && reg_rdata !== want; k++) @(posedge core_clk) #1;
    chk(reg_rdata, want);
    if (k == 20) wrap_up();
  endtask : fire
  task automatic wrap_up();
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : wrap_up
  initial begin
    repeat (12) @(posedge core_clk);
    #1 rst_n = 1;
    pin(8'h05);
    rd(6'h02, 8'h80);
    rd(6'h03, 8'h00);
    rd(6'h04, 8'h14);
    rd(6'h05, 8'h00);
    rd(6'h3f, 8'h00);
    wr(6'h04, 8'h14);
    rd(6'h04, 8'h00);
    wr(6'h04, 8'hff);
    rd(6'h04, 8'h7f);
    wr(6'h04, 8'h7f);
    $display("regs done");
    opt = 1;
    fire(1, 8'h00);
    fne = 1;
    fire(1, 8'h20);
    opt = 0;
    for (int i = 0; i < 12; i++) begin
      wr(i < 8 ? 6'h04 : 6'h05, 8'h7f);
      rd(i < 8 ? 6'h04 : 6'h05, 8'h00);
      fire(i, ew[i]);
    end
    $display("events done");
    wr(6'h05, 8'h9f);
    wr(6'h03, 8'hff);
    rd(6'h03, 8'h9f);
    pin(8'h0a);
    wr(6'h05, 8'h1f);
    pin(8'h07);
    wr(6'h02, 8'h40);
    wr(6'h04, 8'hc0);
    pin(8'h0f);
    wr(6'h03, 8'h00);
    pin(8'h0d);
    wr(6'h02, 8'h3e);
    pin(8'h02);
    $display("pin done");
    wrap_up();
  end
endmodule : nirq_core_tb
